// [logic/apms_map.svh]
`ifndef APMS_MAP_SVH
`define APMS_MAP_SVH

// ****************************************
// Register bus
// ****************************************
`define APMS_ADDR_W 4
`define APMS_DATA_W 32
`define APMS_OFS_CTRL 4'h0
`define APMS_OFS_STATUS 4'h4
`define APMS_OFS_DRIVE 4'h8

// ****************************************
// Control register fields and reset value
// ****************************************
`define APMS_CTRL_EN_BIT 0
`define APMS_CTRL_RST 32'h00000001

// ****************************************
// Status register fields
// ****************************************
`define APMS_ST_STATE_LSB 0
`define APMS_ST_REF_GOOD_BIT 4
`define APMS_ST_STBY_GOOD_BIT 5
`define APMS_ST_BOOT_GOOD_BIT 6
`define APMS_ST_MEM_INREG_BIT 7
`define APMS_ST_OC_LATCH_BIT 8
`define APMS_ST_SUSP_REQ_BIT 9
`define APMS_ST_OFF_REQ_BIT 10

// ****************************************
// Timing
// ****************************************
`define APMS_CLK_MHZ 25
`define APMS_MEM_SS_TIME_US 2000
`define APMS_HUB_SS_TIME_US 1000
`define APMS_MEM_SS_CYCLES (`APMS_MEM_SS_TIME_US * `APMS_CLK_MHZ)
`define APMS_HUB_SS_CYCLES (`APMS_HUB_SS_TIME_US * `APMS_CLK_MHZ)

`endif

// [logic/apms_pkg.sv]
package apms_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STBY_MON,
    ST_BOOT_MON,
    ST_MEM_SS,
    ST_S0,
    ST_S3,
    ST_FAULT
  } apms_state_t;

  // Raw indications from pins and analog comparators
  typedef struct packed {
    logic suspend_standby_req_n;
    logic soft_off_req_n;
    logic standby_above_start;
    logic ref_in_reg;
    logic standby_in_limits;
    logic boot_in_limits;
    logic mem_in_reg;
    logic mem_overcurrent;
  } apms_sense_t;

  // Enables toward the analog regulators and monitors
  typedef struct packed {
    logic ref_enable;
    logic standby_mon_en;
    logic boot_mon_en;
    logic mem_run;
    logic mem_standby;
    logic mem_ss_active;
    logic term_enable;
    logic term_hiz;
    logic hub_run;
    logic hub_ss_active;
  } apms_drive_t;

endpackage

// [logic/apms_sync.sv]
`timescale 1ns/1ps
module apms_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      dout <= '0;
    end else if (ce) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

// [logic/apms_softstart.sv]
`timescale 1ns/1ps
module apms_softstart #(
  parameter int CYCLES = 1000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Control
  input wire logic run,
  output logic done
);

  logic [31:0] cnt_q;

  // Dropping run restarts the interval from zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 32'h00000000;
      done <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_q <= 32'h00000000;
        done <= 1'b0;
      end else if (cnt_q >= 32'(CYCLES - 1)) begin
        done <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h00000001;
      end
    end
  end

endmodule

// [logic/apms_sequencer.sv]
`timescale 1ns/1ps
`include "apms_map.svh"
module apms_sequencer #(
  parameter int MEM_SS_CYCLES = `APMS_MEM_SS_CYCLES,
  parameter int HUB_SS_CYCLES = `APMS_HUB_SS_CYCLES
) (
  // Clock, reset and clock enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Raw indications from pins and comparators
  input wire apms_pkg::apms_sense_t sense_raw,
  // Register port
  input wire logic [`APMS_ADDR_W-1:0] reg_addr,
  input wire logic [`APMS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`APMS_DATA_W-1:0] reg_rdata,
  // Regulator and monitor control
  output apms_pkg::apms_drive_t drive_q,
  // Status indications
  output logic reference_good,
  output logic standby_supply_good,
  output logic boot_supply_good,
  output logic memory_rail_in_regulation
);

  // ****************************************
  // Declarations
  // ****************************************
  apms_pkg::apms_sense_t sense_s;
  apms_pkg::apms_state_t state_q;
  apms_pkg::apms_state_t state_d;
  apms_pkg::apms_drive_t drive_d;
  logic ctrl_en_q;
  logic oc_latch_q;
  logic mem_ss_done;
  logic hub_ss_done;
  logic hub_ss_run;
  logic req_high;
  logic supply_recycled;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_s5(input apms_pkg::apms_state_t st);
    is_s5 = (st == apms_pkg::ST_IDLE) || (st == apms_pkg::ST_STBY_MON) ||
            (st == apms_pkg::ST_BOOT_MON);
  endfunction

  function automatic logic [2:0] state_code(
    input apms_pkg::apms_state_t st
  );
    state_code = st;
  endfunction

  // ****************************************
  // Input synchronisation
  // ****************************************
  apms_sync #(
    .W($bits(apms_pkg::apms_sense_t))
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .din(sense_raw),
    .dout(sense_s)
  );

  assign req_high = sense_s.suspend_standby_req_n &&
                    sense_s.soft_off_req_n;

  // Any of these restarts a latched-off part
  assign supply_recycled = !standby_supply_good ||
                           !sense_s.soft_off_req_n ||
                           !sense_s.boot_in_limits;

  // ****************************************
  // Reference and supply monitors
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reference_good <= 1'b0;
    end else if (ce) begin
      // Regulation is meaningless while the reference is not started
      reference_good <= sense_s.standby_above_start &&
                        sense_s.ref_in_reg;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      standby_supply_good <= 1'b0;
    end else if (ce) begin
      standby_supply_good <= drive_q.standby_mon_en &&
                             sense_s.standby_in_limits;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_supply_good <= 1'b0;
    end else if (ce) begin
      // In S3 this drops with the main supply; state is untouched
      boot_supply_good <= drive_q.boot_mon_en &&
                          sense_s.boot_in_limits;
    end
  end

  // ****************************************
  // Soft-start timers
  // ****************************************
  apms_softstart #(
    .CYCLES(MEM_SS_CYCLES)
  ) u_mem_ss (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run(state_q == apms_pkg::ST_MEM_SS),
    .done(mem_ss_done)
  );

  assign hub_ss_run = (state_q == apms_pkg::ST_S0) &&
                      memory_rail_in_regulation;

  apms_softstart #(
    .CYCLES(HUB_SS_CYCLES)
  ) u_hub_ss (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run(hub_ss_run),
    .done(hub_ss_done)
  );

  // ****************************************
  // Overcurrent latch
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oc_latch_q <= 1'b0;
    end else if (ce) begin
      // Set wins over clear; S3 never sets it
      if (state_q == apms_pkg::ST_S0 && sense_s.mem_overcurrent) begin
        oc_latch_q <= 1'b1;
      end else if (supply_recycled) begin
        oc_latch_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      apms_pkg::ST_IDLE: begin
        if (reference_good && ctrl_en_q) begin
          state_d = apms_pkg::ST_STBY_MON;
        end
      end
      apms_pkg::ST_STBY_MON: begin
        if (standby_supply_good) begin
          state_d = apms_pkg::ST_BOOT_MON;
        end
      end
      apms_pkg::ST_BOOT_MON: begin
        if (boot_supply_good && req_high) begin
          state_d = apms_pkg::ST_MEM_SS;
        end
      end
      apms_pkg::ST_MEM_SS: begin
        if (!req_high || !boot_supply_good) begin
          state_d = apms_pkg::ST_BOOT_MON;
        end else if (mem_ss_done && sense_s.mem_in_reg) begin
          state_d = apms_pkg::ST_S0;
        end
      end
      apms_pkg::ST_S0: begin
        if (sense_s.mem_overcurrent) begin
          state_d = apms_pkg::ST_FAULT;
        end else if (!sense_s.soft_off_req_n) begin
          state_d = apms_pkg::ST_BOOT_MON;
        end else if (!sense_s.suspend_standby_req_n) begin
          state_d = apms_pkg::ST_S3;
        end else if (!boot_supply_good) begin
          state_d = apms_pkg::ST_BOOT_MON;
        end
      end
      apms_pkg::ST_S3: begin
        // Entered with the request low, so a high level is its rise
        if (!sense_s.soft_off_req_n) begin
          state_d = apms_pkg::ST_BOOT_MON;
        end else if (sense_s.suspend_standby_req_n && boot_supply_good) begin
          state_d = apms_pkg::ST_S0;
        end
        // Boot good loss alone causes no move from here
      end
      apms_pkg::ST_FAULT: begin
        if (supply_recycled) begin
          state_d = apms_pkg::ST_STBY_MON;
        end
      end
      default: begin
        state_d = apms_pkg::ST_IDLE;
      end
    endcase
    // Supervisory losses override everything above
    if (!reference_good || !ctrl_en_q) begin
      state_d = apms_pkg::ST_IDLE;
    end else if (!standby_supply_good && !is_s5(state_q) &&
                 state_q != apms_pkg::ST_FAULT) begin
      state_d = apms_pkg::ST_STBY_MON;
    end else if (!standby_supply_good &&
                 state_q == apms_pkg::ST_BOOT_MON) begin
      state_d = apms_pkg::ST_STBY_MON;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= apms_pkg::ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Output decode
  // ****************************************
  always_comb begin
    drive_d = '0;
    drive_d.term_hiz = 1'b1;
    drive_d.ref_enable = sense_s.standby_above_start;
    case (state_d)
      apms_pkg::ST_IDLE: begin
        drive_d.standby_mon_en = 1'b0;
      end
      apms_pkg::ST_STBY_MON: begin
        drive_d.standby_mon_en = 1'b1;
      end
      apms_pkg::ST_BOOT_MON: begin
        drive_d.standby_mon_en = 1'b1;
        drive_d.boot_mon_en = 1'b1;
      end
      apms_pkg::ST_MEM_SS: begin
        drive_d.standby_mon_en = 1'b1;
        drive_d.boot_mon_en = 1'b1;
        drive_d.mem_run = 1'b1;
        drive_d.mem_ss_active = 1'b1;
      end
      apms_pkg::ST_S0: begin
        drive_d.standby_mon_en = 1'b1;
        drive_d.boot_mon_en = 1'b1;
        drive_d.mem_run = 1'b1;
        drive_d.term_enable = memory_rail_in_regulation;
        drive_d.term_hiz = !memory_rail_in_regulation;
        drive_d.hub_run = memory_rail_in_regulation;
        drive_d.hub_ss_active = hub_ss_run && !hub_ss_done;
      end
      apms_pkg::ST_S3: begin
        drive_d.standby_mon_en = 1'b1;
        drive_d.boot_mon_en = 1'b1;
        drive_d.mem_standby = 1'b1;
      end
      apms_pkg::ST_FAULT: begin
        // Monitors stay awake so a recycle can be seen
        drive_d.standby_mon_en = 1'b1;
        drive_d.boot_mon_en = 1'b1;
      end
      default: begin
        drive_d.standby_mon_en = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_q <= '0;
      drive_q.term_hiz <= 1'b1;
    end else if (ce) begin
      drive_q <= drive_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      memory_rail_in_regulation <= 1'b0;
    end else if (ce) begin
      memory_rail_in_regulation <= (state_d == apms_pkg::ST_S0) &&
                                   sense_s.mem_in_reg;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_en_q <= 1'(`APMS_CTRL_RST);
    end else if (ce) begin
      if (reg_wr && reg_addr == `APMS_OFS_CTRL) begin
        ctrl_en_q <= reg_wdata[`APMS_CTRL_EN_BIT];
      end
    end
  end

  // Unmapped reads return zero; data stands one cycle only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          `APMS_OFS_CTRL: begin
            reg_rdata[`APMS_CTRL_EN_BIT] <= ctrl_en_q;
          end
          `APMS_OFS_STATUS: begin
            reg_rdata[`APMS_ST_STATE_LSB +: 3] <= state_code(state_q);
            reg_rdata[`APMS_ST_REF_GOOD_BIT] <= reference_good;
            reg_rdata[`APMS_ST_STBY_GOOD_BIT] <= standby_supply_good;
            reg_rdata[`APMS_ST_BOOT_GOOD_BIT] <= boot_supply_good;
            reg_rdata[`APMS_ST_MEM_INREG_BIT] <= memory_rail_in_regulation;
            reg_rdata[`APMS_ST_OC_LATCH_BIT] <= oc_latch_q;
            reg_rdata[`APMS_ST_SUSP_REQ_BIT] <=
              sense_s.suspend_standby_req_n;
            reg_rdata[`APMS_ST_OFF_REQ_BIT] <= sense_s.soft_off_req_n;
          end
          `APMS_OFS_DRIVE: begin
            reg_rdata[$bits(apms_pkg::apms_drive_t)-1:0] <= drive_q;
          end
          default: begin
            reg_rdata <= '0;
          end
        endcase
      end
    end
  end

endmodule

// [sim/apms_sequencer_sva.sv]
`timescale 1ns/1ps
`include "apms_map.svh"
module apms_seq_sva #(
  parameter int MEM_SS_CYCLES = 8,
  parameter int HUB_SS_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Inputs
  input wire apms_pkg::apms_sense_t sense_raw,
  input wire logic [`APMS_ADDR_W-1:0] reg_addr,
  input wire logic [`APMS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Outputs
  input wire logic [`APMS_DATA_W-1:0] reg_rdata,
  input wire apms_pkg::apms_drive_t drive_q,
  input wire logic reference_good,
  input wire logic standby_supply_good,
  input wire logic boot_supply_good,
  input wire logic memory_rail_in_regulation
);
  // ****
  // Sequencing checks
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_ref_late;
    $rose(reference_good) |-> $past(sense_raw.ref_in_reg, 3);
  endproperty
  a_ref_late: assert property (p_ref_late)
    else $error("reference good without reference in regulation");
  property p_idle_no_ref;
    !reference_good [*2] |-> !drive_q.standby_mon_en && !drive_q.mem_run;
  endproperty
  a_idle_no_ref: assert property (p_idle_no_ref)
    else $error("sequencer active without reference good");
  property p_stby_first;
    $rose(drive_q.standby_mon_en) |-> reference_good && !drive_q.boot_mon_en
      && !drive_q.mem_run && !drive_q.hub_run;
  endproperty
  a_stby_first: assert property (p_stby_first)
    else $error("standby monitor not first");
  property p_boot_after;
    $rose(drive_q.boot_mon_en) |-> $past(standby_supply_good);
  endproperty
  a_boot_after: assert property (p_boot_after)
    else $error("boot monitor enabled before standby good");
  property p_ss_start;
    $rose(drive_q.mem_ss_active) |-> $past(boot_supply_good);
  endproperty
  a_ss_start: assert property (p_ss_start)
    else $error("soft-start without boot good");
  property p_s0_entry;
    $rose(drive_q.mem_run) |->
      $past(reference_good && standby_supply_good && boot_supply_good);
  endproperty
  a_s0_entry: assert property (p_s0_entry)
    else $error("normal run entered without all supplies good");
  property p_inreg_en;
    $rose(memory_rail_in_regulation) |=>
      drive_q.term_enable && drive_q.hub_run;
  endproperty
  a_inreg_en: assert property (p_inreg_en)
    else $error("termination and hub not enabled");
  property p_hub_ss;
    $rose(drive_q.hub_run) |-> drive_q.hub_ss_active;
  endproperty
  a_hub_ss: assert property (p_hub_ss)
    else $error("hub soft-start not active at hub enable");
  property p_boot_mon;
    $rose(boot_supply_good) |-> $past(drive_q.boot_mon_en);
  endproperty
  a_boot_mon: assert property (p_boot_mon)
    else $error("boot good without its monitor");
  property p_sleep_out;
    drive_q.mem_standby |-> drive_q.term_hiz && !drive_q.hub_run
      && !drive_q.mem_run && !drive_q.term_enable;
  endproperty
  a_sleep_out: assert property (p_sleep_out)
    else $error("sleep outputs wrong");
  property p_term_drive;
    drive_q.term_enable |-> !drive_q.term_hiz && drive_q.mem_run;
  endproperty
  a_term_drive: assert property (p_term_drive)
    else $error("termination driven outside normal run");
  property p_stby_loss;
    $fell(standby_supply_good) |=> !drive_q.mem_run && !drive_q.mem_ss_active;
  endproperty
  a_stby_loss: assert property (p_stby_loss)
    else $error("run continues after standby loss");
endmodule

bind apms_sequencer apms_seq_sva #(.MEM_SS_CYCLES(MEM_SS_CYCLES),
  .HUB_SS_CYCLES(HUB_SS_CYCLES)) i_sva (.clk(clk), .sys_rst(sys_rst),
  .ce(ce), .sense_raw(sense_raw), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .drive_q(drive_q),
  .reference_good(reference_good), .standby_supply_good(standby_supply_good),
  .boot_supply_good(boot_supply_good),
  .memory_rail_in_regulation(memory_rail_in_regulation));

// [sim/apms_chipset_model.sv]
`timescale 1ns/1ps
module apms_chipset_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Commands and response lag
  input wire logic sleep_cmd,
  input wire logic off_cmd,
  input wire logic [1:0] lag,
  // Sleep request pins
  output logic suspend_standby_req_n,
  output logic soft_off_req_n
);
  logic [1:0] wait_q;
  logic pend;
  assign pend = (suspend_standby_req_n == sleep_cmd) ||
    (soft_off_req_n == off_cmd);
  // A slow chipset answers only after lag idle cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 2'h0;
      suspend_standby_req_n <= 1'b1;
      soft_off_req_n <= 1'b1;
    end else if (pend && wait_q >= lag) begin
      wait_q <= 2'h0;
      suspend_standby_req_n <= !sleep_cmd;
      soft_off_req_n <= !off_cmd;
    end else if (pend) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
`include "apms_map.svh"
module tb_top;
  logic clk, sys_rst, ce, reg_wr, reg_rd, sleep_cmd, off_cmd, oc;
  logic susp_n, off_n, ref_good, stby_good, boot_good, mem_inreg;
  logic [1:0] lag;
  logic [4:0] supp;
  logic [`APMS_ADDR_W-1:0] reg_addr;
  logic [`APMS_DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
  logic [31:0] lfsr;
  apms_pkg::apms_sense_t sense;
  apms_pkg::apms_drive_t drive_q;
  int bad_count, tests_run;
  assign sense = {susp_n, off_n, supp, oc};

  apms_sequencer #(.MEM_SS_CYCLES(8), .HUB_SS_CYCLES(4)) i_dut (.clk(clk),
    .sys_rst(sys_rst), .ce(ce), .sense_raw(sense), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .drive_q(drive_q), .reference_good(ref_good),
    .standby_supply_good(stby_good), .boot_supply_good(boot_good),
    .memory_rail_in_regulation(mem_inreg));
  apms_chipset_model i_chipset (.clk(clk), .sys_rst(sys_rst),
    .sleep_cmd(sleep_cmd), .off_cmd(off_cmd), .lag(lag),
    .suspend_standby_req_n(susp_n), .soft_off_req_n(off_n));

  // ****
  // Helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected {mem_run, mem_standby, term_enable, term_hiz, hub_run}
  function automatic logic [4:0] exp_out(input logic [2:0] st);
    case (st)
      3'h4: return 5'h15;
      3'h5: return 5'h0A;
      default: return 5'h02;
    endcase
  endfunction
  function automatic logic [31:0] outs();
    return 32'({drive_q.mem_run, drive_q.mem_standby, drive_q.term_enable,
      drive_q.term_hiz, drive_q.hub_run});
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Polls the state code; a bound keeps a stuck design from hanging here
  task automatic wait_st(input logic [2:0] st);
    int n;
    n = 0;
    do begin
      rd(`APMS_OFS_STATUS);
      n++;
    end while (rd_val[2:0] !== st && n < 100);
    if (rd_val[2:0] !== st) begin
      bad_count++;
      $display("Error at %0t: state %0h never reached", $time, st);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    sleep_cmd = 1'b0;
    off_cmd = 1'b0;
    lag = 2'h0;
    supp = 5'h00;
    oc = 1'b0;
    lfsr = 32'h895E;
    bad_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`APMS_OFS_CTRL);
    chk(rd_val, `APMS_CTRL_RST);
    chk(32'(drive_q), 32'h4);
    wr(`APMS_OFS_STATUS, 32'hFFFFFFFF);
    rd(4'hC);
    chk(rd_val, 32'h0);
    supp <= 5'h10;
    repeat (8) @(posedge clk);
    rd(`APMS_OFS_STATUS);
    chk(32'({ref_good, rd_val[2:0]}), 32'h0);
    $display("Test reset done");
    supp <= 5'h18;
    wait_st(3'h1);
    chk(32'({ref_good, drive_q[8:7]}), 32'h6);
    supp <= 5'h1C;
    wait_st(3'h2);
    chk(32'({stby_good, drive_q.boot_mon_en}), 32'h3);
    sleep_cmd <= 1'b1;
    supp <= 5'h1E;
    repeat (12) @(posedge clk);
    rd(`APMS_OFS_STATUS);
    chk(32'(rd_val[2:0]), 32'h2);
    sleep_cmd <= 1'b0;
    wait_st(3'h3);
    chk(32'(drive_q.mem_ss_active), 32'h1);
    supp <= 5'h1F;
    wait_st(3'h4);
    repeat (4) @(posedge clk);
    chk(32'({mem_inreg, boot_good}), 32'h3);
    chk(outs(), 32'(exp_out(3'h4)));
    // Clock enable low must freeze the outputs although a request moves
    ce <= 1'b0;
    sleep_cmd <= 1'b1;
    repeat (10) @(posedge clk);
    chk(outs(), 32'(exp_out(3'h4)));
    ce <= 1'b1;
    $display("Test power-up done");
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      lag <= lfsr[1:0];
      sleep_cmd <= 1'b1;
      wait_st(3'h5);
      chk(outs(), 32'(exp_out(3'h5)));
      supp <= lfsr[2] ? 5'h1D : 5'h1F;
      oc <= lfsr[3];
      repeat (4 + lfsr[7:4]) @(posedge clk);
      rd(`APMS_OFS_STATUS);
      chk(32'(rd_val[2:0]), 32'h5);
      supp <= 5'h1F;
      oc <= 1'b0;
      sleep_cmd <= 1'b0;
      wait_st(3'h4);
      chk(outs(), 32'(exp_out(3'h4)));
    end
    $display("Test sleep cycles done");
    oc <= 1'b1;
    wait_st(3'h6);
    chk(outs(), 32'(exp_out(3'h6)));
    oc <= 1'b0;
    repeat (6) @(posedge clk);
    rd(`APMS_OFS_STATUS);
    chk(32'(rd_val[2:0]), 32'h6);
    chk(32'(rd_val[`APMS_ST_OC_LATCH_BIT]), 32'h1);
    supp <= 5'h1D;
    wait_st(3'h2);
    chk(32'(rd_val[2:0]), 32'h2);
    supp <= 5'h1F;
    wait_st(3'h4);
    $display("Test overcurrent done");
    off_cmd <= 1'b1;
    wait_st(3'h2);
    chk(outs(), 32'(exp_out(3'h2)));
    off_cmd <= 1'b0;
    wait_st(3'h4);
    chk(outs(), 32'(exp_out(3'h4)));
    supp <= 5'h1B;
    wait_st(3'h1);
    chk(outs(), 32'(exp_out(3'h1)));
    supp <= 5'h1F;
    wait_st(3'h4);
    supp <= 5'h17;
    wait_st(3'h0);
    chk(32'({ref_good, outs()}), 32'(exp_out(3'h0)));
    rd(`APMS_OFS_DRIVE);
    chk(rd_val, 32'h00000204);
    wr(`APMS_OFS_CTRL, 32'h00000000);
    rd(`APMS_OFS_CTRL);
    chk(rd_val, 32'h00000000);
    $display("Test shutdown done");
    complete_run();
  end
endmodule
